/* hdl/jrxcfg_map.svh */
// register offsets, field positions, reset values and frame counts of the receive link configuration bank
`ifndef JRXCFG_MAP_SVH
`define JRXCFG_MAP_SVH

`define JRXCFG_ADDR_W          15
`define JRXCFG_INSTR_BITS      5'h10
`define JRXCFG_DATA_BITS       4'h8

`define JRXCFG_OFS_LANE_SCR    15'h0453
`define JRXCFG_OFS_OPF_M1      15'h0454
`define JRXCFG_OFS_FPMF        15'h0455
`define JRXCFG_OFS_CONV        15'h0456
`define JRXCFG_OFS_CS_RES      15'h0457
`define JRXCFG_OFS_SUB_NP      15'h0458
`define JRXCFG_OFS_VER_SPF     15'h0459
`define JRXCFG_OFS_HD_CF       15'h045A
`define JRXCFG_OFS_DESKEW      15'h046C
`define JRXCFG_OFS_OPF_DIRECT  15'h0476
`define JRXCFG_OFS_ENABLE      15'h047D

`define JRXCFG_RST_LANE_SCR    8'h03
`define JRXCFG_RST_OPF_M1      8'h00
`define JRXCFG_RST_FPMF        8'h1F
`define JRXCFG_RST_CONV        8'h00
`define JRXCFG_RST_CS_RES      8'h0F
`define JRXCFG_RST_SUB_NP      8'h0F
`define JRXCFG_RST_VER_SPF     8'h21
`define JRXCFG_RST_HD_CF       8'h80
`define JRXCFG_RST_DESKEW      8'hFF
`define JRXCFG_RST_OPF_DIRECT  8'h01
`define JRXCFG_RST_ENABLE      8'hFF

`define JRXCFG_SCR_BIT         7
`define JRXCFG_HD_BIT          7
`define JRXCFG_RES_16          5'h0F
`define JRXCFG_NP_16           5'h0F
`define JRXCFG_VER_B           3'h1
`define JRXCFG_K_16_M1         5'h0F

`endif

/* hdl/jrxcfg_pkg.sv */
// types shared by the receive link configuration bank
package jrxcfg_pkg;

    typedef enum logic [1:0] {
        JRXCFG_ST_INSTR,
        JRXCFG_ST_DATA,
        JRXCFG_ST_DONE
    } jrxcfg_spi_e;

    typedef struct packed {
        logic       descramble_en;
        logic [5:0] lanes_per_link;
        logic [8:0] octets_per_frame;
        logic [5:0] frames_per_mf;
        logic [8:0] converters;
        logic       subclass1;
        logic [5:0] samples_per_frame;
        logic       high_density;
    } jrxcfg_link_s;

endpackage

/* hdl/jrxcfg_top.sv */
// serial-port configuration register bank and parameter decode for the receive deframer
//
// Functional notes
// - lane-count register bit 7 zero disables descrambling, one enables it
// - five-bit lane field is lane count minus one
// - octets-per-frame register is octet count minus one
// - frames-per-multiframe field is count minus one; sixteen only with two-octet frames
// - converters-per-link register must be zero, meaning one converter
// - control bits must be zero, resolution field must be 0x0F
// - subclass field selects subclass 0 or 1; sample width field must be 0xF
// - version field must be 1; samples-per-frame field is count minus one
// - high-density bit set for one-octet frames; control words field zero
// - deskew mask holds one bit per logical lane, all eight in mode 10
// - mode 12 uses masks 0x33: lanes 0, 1, 4, 5
// - mode 13 uses masks 0x11: lanes 0 and 4
// - second octets-per-frame register holds the octet count directly
// - receiver counts differ from transmitter's; transmitter uses true counts
// - mask bit one deskews or enables that lane, zero marks it unused
// - on the second link, link lane x is logical lane x plus four
`timescale 1ns/10ps
`default_nettype none
`include "jrxcfg_map.svh"

module jrxcfg_top
    import jrxcfg_pkg::*;
#(
    parameter int NUM_REGS  = 11,
    parameter int NUM_LANES = 8
) (
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    input  wire logic                   spi_cs_n,
    input  wire logic                   spi_sclk,
    input  wire logic                   spi_sdi,
    output var  logic                   spi_sdo_o,
    output var  logic                   spi_sdo_oe,
    input  wire logic                   link_sel,
    output var  jrxcfg_link_s           link_cfg,
    output var  logic [NUM_LANES-1:0]   deskew_lanes,
    output var  logic [NUM_LANES-1:0]   enabled_lanes,
    output var  logic [NUM_LANES/2-1:0] link_deskew,
    output var  logic [NUM_LANES/2-1:0] link_enable,
    output var  logic [3:0]             true_lane_count,
    output var  logic                   cfg_error
);

    localparam logic [`JRXCFG_ADDR_W-1:0] OFS [NUM_REGS] = '{
        `JRXCFG_OFS_LANE_SCR, `JRXCFG_OFS_OPF_M1, `JRXCFG_OFS_FPMF, `JRXCFG_OFS_CONV,
        `JRXCFG_OFS_CS_RES, `JRXCFG_OFS_SUB_NP, `JRXCFG_OFS_VER_SPF, `JRXCFG_OFS_HD_CF,
        `JRXCFG_OFS_DESKEW, `JRXCFG_OFS_OPF_DIRECT, `JRXCFG_OFS_ENABLE};
    localparam logic [7:0] RST [NUM_REGS] = '{
        `JRXCFG_RST_LANE_SCR, `JRXCFG_RST_OPF_M1, `JRXCFG_RST_FPMF, `JRXCFG_RST_CONV,
        `JRXCFG_RST_CS_RES, `JRXCFG_RST_SUB_NP, `JRXCFG_RST_VER_SPF, `JRXCFG_RST_HD_CF,
        `JRXCFG_RST_DESKEW, `JRXCFG_RST_OPF_DIRECT, `JRXCFG_RST_ENABLE};

    localparam int I_LANE = 0;
    localparam int I_OPF  = 1;
    localparam int I_FPMF = 2;
    localparam int I_CONV = 3;
    localparam int I_CSR  = 4;
    localparam int I_SUB  = 5;
    localparam int I_VER  = 6;
    localparam int I_HD   = 7;
    localparam int I_DSK  = 8;
    localparam int I_OPFD = 9;
    localparam int I_ENA  = 10;

    // serial port state
    jrxcfg_spi_e                state_reg;
    jrxcfg_spi_e                state_next;
    logic                       sclk_reg;
    logic                       sclk_next;
    logic [4:0]                 bit_cnt_reg;
    logic [4:0]                 bit_cnt_next;
    logic [15:0]                instr_reg;
    logic [15:0]                instr_next;
    logic [7:0]                 wdata_reg;
    logic [7:0]                 wdata_next;
    logic [7:0]                 rd_sr_reg;
    logic [7:0]                 rd_sr_next;
    logic                       sdo_reg;
    logic                       sdo_next;
    logic                       sdo_oe_reg;
    logic                       sdo_oe_next;

    // register bank
    logic [7:0]                 bank_reg  [NUM_REGS];
    logic [7:0]                 bank_next [NUM_REGS];

    // decoded outputs
    jrxcfg_link_s               cfg_reg;
    jrxcfg_link_s               cfg_next;
    logic [NUM_LANES-1:0]       dsk_reg;
    logic [NUM_LANES-1:0]       ena_reg;
    logic [NUM_LANES/2-1:0]     ldsk_reg;
    logic [NUM_LANES/2-1:0]     ldsk_next;
    logic [NUM_LANES/2-1:0]     lena_reg;
    logic [NUM_LANES/2-1:0]     lena_next;
    logic [3:0]                 tlc_reg;
    logic [3:0]                 tlc_next;
    logic                       err_reg;
    logic                       err_next;

    logic                       rise;
    logic                       fall;
    logic [`JRXCFG_ADDR_W-1:0]  addr;
    logic [NUM_REGS-1:0]        hit;
    logic [7:0]                 rdata;

    // sclk edges against its last sample; idle low matches reset, so no false edge
    assign rise = spi_sclk & ~sclk_reg & ~spi_cs_n;
    assign fall = ~spi_sclk & sclk_reg & ~spi_cs_n;
    assign addr = instr_reg[`JRXCFG_ADDR_W-1:0];

    // address decode, one comparator per register
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_hit
            assign hit[gi] = (addr == OFS[gi]);
        end
    endgenerate

    // read mux; an unmapped address reads as zero
    always_comb begin
        rdata = 8'h00;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (hit[i]) begin
                rdata = bank_reg[i];
            end
        end
    end

    // serial frame: 16-bit instruction (read flag, 15-bit address) then one data byte
    always_comb begin
        state_next   = state_reg;
        sclk_next    = spi_sclk;
        bit_cnt_next = bit_cnt_reg;
        instr_next   = instr_reg;
        wdata_next   = wdata_reg;
        rd_sr_next   = rd_sr_reg;
        sdo_next     = sdo_reg;
        sdo_oe_next  = sdo_oe_reg;
        for (int i = 0; i < NUM_REGS; i++) begin
            bank_next[i] = bank_reg[i];
        end
        if (spi_cs_n) begin
            state_next   = JRXCFG_ST_INSTR;
            bit_cnt_next = 5'h00;
            sdo_oe_next  = 1'b0;
        end else begin
            unique case (state_reg)
                JRXCFG_ST_INSTR: begin
                    if (rise) begin
                        instr_next   = {instr_reg[14:0], spi_sdi};
                        bit_cnt_next = bit_cnt_reg + 5'h01;
                        if (bit_cnt_reg == `JRXCFG_INSTR_BITS - 5'h01) begin
                            state_next   = JRXCFG_ST_DATA;
                            bit_cnt_next = 5'h00;
                        end
                    end
                end
                JRXCFG_ST_DATA: begin
                    if (instr_reg[15]) begin
                        if (fall) begin
                            sdo_oe_next = 1'b1;
                            sdo_next    = (bit_cnt_reg == 5'h00) ? rdata[7] : rd_sr_reg[7];
                            rd_sr_next  = (bit_cnt_reg == 5'h00) ? {rdata[6:0], 1'b0}
                                                                 : {rd_sr_reg[6:0], 1'b0};
                        end
                        if (rise) begin
                            bit_cnt_next = bit_cnt_reg + 5'h01;
                            if (bit_cnt_reg == 5'({1'b0, `JRXCFG_DATA_BITS}) - 5'h01) begin
                                state_next = JRXCFG_ST_DONE;
                            end
                        end
                    end else if (rise) begin
                        wdata_next   = {wdata_reg[6:0], spi_sdi};
                        bit_cnt_next = bit_cnt_reg + 5'h01;
                        // byte lands only with the eighth data bit; a cut frame writes nothing
                        if (bit_cnt_reg == 5'({1'b0, `JRXCFG_DATA_BITS}) - 5'h01) begin
                            state_next = JRXCFG_ST_DONE;
                            for (int i = 0; i < NUM_REGS; i++) begin
                                if (hit[i]) begin
                                    bank_next[i] = {wdata_reg[6:0], spi_sdi};
                                end
                            end
                        end
                    end
                end
                JRXCFG_ST_DONE: begin
                    if (fall) begin
                        sdo_oe_next = 1'b0;
                    end
                end
                default: begin
                    state_next = JRXCFG_ST_INSTR;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg   <= JRXCFG_ST_INSTR;
            sclk_reg    <= 1'b0;
            bit_cnt_reg <= 5'h00;
            instr_reg   <= 16'h0000;
            wdata_reg   <= 8'h00;
            rd_sr_reg   <= 8'h00;
            sdo_reg     <= 1'b0;
            sdo_oe_reg  <= 1'b0;
            for (int i = 0; i < NUM_REGS; i++) begin
                bank_reg[i] <= RST[i];
            end
        end else begin
            state_reg   <= state_next;
            sclk_reg    <= sclk_next;
            bit_cnt_reg <= bit_cnt_next;
            instr_reg   <= instr_next;
            wdata_reg   <= wdata_next;
            rd_sr_reg   <= rd_sr_next;
            sdo_reg     <= sdo_next;
            sdo_oe_reg  <= sdo_oe_next;
            for (int i = 0; i < NUM_REGS; i++) begin
                bank_reg[i] <= bank_next[i];
            end
        end
    end

    // parameter decode and consistency check
    always_comb begin
        cfg_next.descramble_en     = bank_reg[I_LANE][`JRXCFG_SCR_BIT];
        cfg_next.lanes_per_link    = {1'b0, bank_reg[I_LANE][4:0]} + 6'h01;
        cfg_next.octets_per_frame  = {1'b0, bank_reg[I_OPF]} + 9'h001;
        cfg_next.frames_per_mf     = {1'b0, bank_reg[I_FPMF][4:0]} + 6'h01;
        cfg_next.converters        = {1'b0, bank_reg[I_CONV]} + 9'h001;
        cfg_next.subclass1         = (bank_reg[I_SUB][7:5] == 3'h1);
        cfg_next.samples_per_frame = {1'b0, bank_reg[I_VER][4:0]} + 6'h01;
        cfg_next.high_density      = bank_reg[I_HD][`JRXCFG_HD_BIT];
        err_next = 1'b0;
        if (bank_reg[I_CONV] != 8'h00) begin
            err_next = 1'b1;
        end
        if (bank_reg[I_CSR][7:6] != 2'h0 || bank_reg[I_CSR][4:0] != `JRXCFG_RES_16) begin
            err_next = 1'b1;
        end
        if (bank_reg[I_SUB][7:5] > 3'h1 || bank_reg[I_SUB][4:0] != `JRXCFG_NP_16) begin
            err_next = 1'b1;
        end
        if (bank_reg[I_VER][7:5] != `JRXCFG_VER_B) begin
            err_next = 1'b1;
        end
        if (bank_reg[I_HD][4:0] != 5'h00 || bank_reg[I_HD][`JRXCFG_HD_BIT] != (bank_reg[I_OPF] == 8'h00)) begin
            err_next = 1'b1;
        end
        if (bank_reg[I_FPMF][4:0] == `JRXCFG_K_16_M1 && bank_reg[I_OPF] != 8'h01) begin
            err_next = 1'b1;
        end
        if ({1'b0, bank_reg[I_OPFD]} != {1'b0, bank_reg[I_OPF]} + 9'h001) begin
            err_next = 1'b1;
        end
        // transmitter's lane count is the population of the enable mask
        tlc_next = 4'h0;
        for (int i = 0; i < NUM_LANES; i++) begin
            tlc_next = tlc_next + {3'h0, bank_reg[I_ENA][i]};
        end
        // a lane is steered only where mask bit is one; modes 10, 12, 13 use 0xFF, 0x33, 0x11
        ldsk_next = link_sel ? bank_reg[I_DSK][7:4] : bank_reg[I_DSK][3:0];
        lena_next = link_sel ? bank_reg[I_ENA][7:4] : bank_reg[I_ENA][3:0];
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg_reg  <= '0;
            dsk_reg  <= '0;
            ena_reg  <= '0;
            ldsk_reg <= '0;
            lena_reg <= '0;
            tlc_reg  <= 4'h0;
            err_reg  <= 1'b0;
        end else begin
            cfg_reg  <= cfg_next;
            dsk_reg  <= bank_reg[I_DSK];
            ena_reg  <= bank_reg[I_ENA];
            ldsk_reg <= ldsk_next;
            lena_reg <= lena_next;
            tlc_reg  <= tlc_next;
            err_reg  <= err_next;
        end
    end

    // every output comes straight from a register
    assign spi_sdo_o       = sdo_reg;
    assign spi_sdo_oe      = sdo_oe_reg;
    assign link_cfg        = cfg_reg;
    assign deskew_lanes    = dsk_reg;
    assign enabled_lanes   = ena_reg;
    assign link_deskew     = ldsk_reg;
    assign link_enable     = lena_reg;
    assign true_lane_count = tlc_reg;
    assign cfg_error       = err_reg;

endmodule

`default_nettype wire

/* sim/jrxcfg_top_assertions.sv */
// assertion checker for the receive link configuration bank
`timescale 1ns/10ps
`default_nettype none
module jrxcfg_top_assertions
    import jrxcfg_pkg::*;
#(
    parameter int NUM_LANES = 8
) (
    input wire logic                   clock,
    input wire logic                   rst_n,
    input wire logic                   spi_cs_n,
    input wire logic                   link_sel,
    input wire jrxcfg_link_s           link_cfg,
    input wire logic [NUM_LANES-1:0]   deskew_lanes,
    input wire logic [NUM_LANES-1:0]   enabled_lanes,
    input wire logic [NUM_LANES/2-1:0] link_deskew,
    input wire logic [NUM_LANES/2-1:0] link_enable,
    input wire logic [3:0]             true_lane_count,
    input wire logic                   cfg_error
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_link_deskew;
        link_deskew == ($past(link_sel) ? deskew_lanes[NUM_LANES-1:NUM_LANES/2] : deskew_lanes[NUM_LANES/2-1:0]);
    endproperty
    a_link_deskew: assert property (p_link_deskew) else $error("link deskew slice wrong");
    property p_link_enable;
        link_enable == ($past(link_sel) ? enabled_lanes[NUM_LANES-1:NUM_LANES/2] : enabled_lanes[NUM_LANES/2-1:0]);
    endproperty
    a_link_enable: assert property (p_link_enable) else $error("link enable slice wrong");
    property p_lane_count;
        true_lane_count == $countones(enabled_lanes);
    endproperty
    a_lane_count: assert property (p_lane_count) else $error("true lane count wrong");
    property p_density;
        !cfg_error |-> link_cfg.high_density == (link_cfg.octets_per_frame == 9'h001);
    endproperty
    a_density: assert property (p_density) else $error("high density without error flag");
    property p_conv;
        !cfg_error |-> link_cfg.converters <= 9'h001;
    endproperty
    a_conv: assert property (p_conv) else $error("converter count without error flag");
    property p_fpmf;
        !cfg_error && link_cfg.frames_per_mf == 6'h10 |-> link_cfg.octets_per_frame == 9'h002;
    endproperty
    a_fpmf: assert property (p_fpmf) else $error("sixteen frames with one-octet frames");
    property p_cfg_stable;
        (rst_n && spi_cs_n) [*3] |-> $stable(link_cfg);
    endproperty
    a_cfg_stable: assert property (p_cfg_stable) else $error("decode changed without a frame");
    property p_mask_stable;
        spi_cs_n ##1 spi_cs_n [*2] |-> $stable({deskew_lanes, enabled_lanes});
    endproperty
    a_mask_stable: assert property (p_mask_stable) else $error("masks changed without a frame");
    property p_nonzero;
        $past(rst_n) |-> link_cfg.lanes_per_link != 6'h00 && link_cfg.octets_per_frame != 9'h000;
    endproperty
    a_nonzero: assert property (p_nonzero) else $error("minus-one count decoded as zero");
endmodule
`default_nettype wire

/* sim/jrxcfg_spi_host.sv */
// serial control port host model driving the configuration bank
`timescale 1ns/10ps
`default_nettype none
module jrxcfg_spi_host (
    input  wire logic clock,
    input  wire logic spi_sdo_o,
    input  wire logic spi_sdo_oe,
    output var  logic spi_cs_n,
    output var  logic spi_sclk,
    output var  logic spi_sdi
);
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_sdi  = 1'b0;
    end
    // frame of nb bits; fewer than 24 aborts it; undriven sdo reads unknown
    task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wd, input int nb,
                        output logic [7:0] q);
        logic [23:0] frame;
        frame = {rd, addr, wd};
        q = 8'hXX;
        @(negedge clock);
        spi_cs_n = 1'b0;
        @(negedge clock);
        for (int k = 0; k < nb; k++) begin
            // sdo taken as sclk rises; the device shifted it on the fall before
            if (k >= 16) begin
                q[23-k] = spi_sdo_oe ? spi_sdo_o : 1'bx;
            end
            spi_sdi  = frame[23-k];
            spi_sclk = 1'b1;
            repeat (2) @(negedge clock);
            spi_sclk = 1'b0;
            repeat (2) @(negedge clock);
        end
        spi_cs_n = 1'b1;
        spi_sdi  = ~spi_sdi;
        @(negedge clock);
    endtask
endmodule
`default_nettype wire

/* sim/jrxcfg_top_test.sv */
// self-checking testbench for the receive link configuration bank
`timescale 1ns/10ps
`default_nettype none
module jrxcfg_top_test;
    import jrxcfg_pkg::*;
    logic         clock, rst_n, spi_cs_n, spi_sclk, spi_sdi, spi_sdo_o, spi_sdo_oe, link_sel, cfg_error;
    jrxcfg_link_s link_cfg;
    logic [7:0]   deskew_lanes, enabled_lanes;
    logic [3:0]   link_deskew, link_enable, true_lane_count;
    int           n_errors = 0;
    int           n_tests  = 0;
    logic [7:0]   r [11];
    logic [14:0]  ofs [11] = '{15'h0453, 15'h0454, 15'h0455, 15'h0456, 15'h0457, 15'h0458, 15'h0459,
                               15'h045A, 15'h046C, 15'h0476, 15'h047D};
    logic [7:0]   rv [11] = '{8'h03, 8'h00, 8'h1F, 8'h00, 8'h0F, 8'h0F, 8'h21, 8'h80, 8'hFF, 8'h01, 8'hFF};
    logic [7:0]   mv [3][11] = '{'{8'h80, 8'h01, 8'h0F, 8'h00, 8'h0F, 8'h2F, 8'h20, 8'h00, 8'h11, 8'h02, 8'h11},
                                 '{8'h01, 8'h00, 8'h1F, 8'h00, 8'h0F, 8'h0F, 8'h20, 8'h80, 8'h33, 8'h01, 8'h33},
                                 '{8'h83, 8'h00, 8'h1F, 8'h00, 8'h0F, 8'h2F, 8'h21, 8'h80, 8'hFF, 8'h01, 8'hFF}};
    int           bi [9] = '{3, 4, 4, 5, 6, 7, 7, 9, 2};
    logic [7:0]   bv [9] = '{8'h01, 8'h4F, 8'h0E, 8'h4F, 8'h41, 8'h00, 8'h81, 8'h02, 8'h0F};

    jrxcfg_top i_jrxcfg_top (.clock(clock), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
        .spi_sdi(spi_sdi), .spi_sdo_o(spi_sdo_o), .spi_sdo_oe(spi_sdo_oe), .link_sel(link_sel),
        .link_cfg(link_cfg), .deskew_lanes(deskew_lanes), .enabled_lanes(enabled_lanes),
        .link_deskew(link_deskew), .link_enable(link_enable), .true_lane_count(true_lane_count),
        .cfg_error(cfg_error));
    jrxcfg_spi_host i_jrxcfg_spi_host (.clock(clock), .spi_sdo_o(spi_sdo_o), .spi_sdo_oe(spi_sdo_oe),
        .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi));

    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input int i, input logic [7:0] v);
        logic [7:0] q;
        i_jrxcfg_spi_host.xfer(1'b0, ofs[i], v, 24, q);
        r[i] = v;
    endtask
    task automatic rd_chk(input int i);
        logic [7:0] q;
        i_jrxcfg_spi_host.xfer(1'b1, ofs[i], 8'h00, 24, q);
        chk("readback", 64'(r[i]), 64'(q));
    endtask
    // decoded outputs expected from the register model
    task automatic chk_decode(input logic err);
        jrxcfg_link_s e;
        e.descramble_en     = r[0][7];
        e.lanes_per_link    = {1'b0, r[0][4:0]} + 6'h01;
        e.octets_per_frame  = {1'b0, r[1]} + 9'h001;
        e.frames_per_mf     = {1'b0, r[2][4:0]} + 6'h01;
        e.converters        = {1'b0, r[3]} + 9'h001;
        e.subclass1         = (r[5][7:5] == 3'h1);
        e.samples_per_frame = {1'b0, r[6][4:0]} + 6'h01;
        e.high_density      = r[7][7];
        repeat (2) @(negedge clock);
        chk("link_cfg", 64'(e), 64'(link_cfg));
        chk("deskew_lanes", 64'(r[8]), 64'(deskew_lanes));
        chk("enabled_lanes", 64'(r[10]), 64'(enabled_lanes));
        chk("true_lane_count", 64'($countones(r[10])), 64'(true_lane_count));
        chk("cfg_error", 64'(err), 64'(cfg_error));
        for (int s = 0; s < 2; s++) begin
            link_sel = s[0];
            repeat (2) @(negedge clock);
            chk("link_deskew", 64'(s ? r[8][7:4] : r[8][3:0]), 64'(link_deskew));
            chk("link_enable", 64'(s ? r[10][7:4] : r[10][3:0]), 64'(link_enable));
        end
    endtask
    task automatic t_reset();
        for (int i = 0; i < 11; i++) begin
            r[i] = rv[i];
            rd_chk(i);
        end
        chk_decode(1'b0);
    endtask
    task automatic t_modes();
        for (int m = 0; m < 3; m++) begin
            for (int i = 0; i < 11; i++) begin
                wr(i, mv[m][i]);
                rd_chk(i);
            end
            chk_decode(1'b0);
        end
    endtask
    task automatic t_error();
        logic [7:0] old;
        for (int k = 0; k < 9; k++) begin
            old = r[bi[k]];
            wr(bi[k], bv[k]);
            chk_decode(1'b1);
            wr(bi[k], old);
        end
        chk_decode(1'b0);
    endtask
    task automatic t_abort();
        logic [7:0] q;
        i_jrxcfg_spi_host.xfer(1'b0, ofs[8], 8'h00, 20, q);
        rd_chk(8);
        i_jrxcfg_spi_host.xfer(1'b0, 15'h0460, 8'h5A, 24, q);
        i_jrxcfg_spi_host.xfer(1'b1, 15'h0460, 8'h00, 24, q);
        chk("unmapped", 64'h0, 64'(q));
        chk_decode(1'b0);
    endtask
    task automatic close_out();
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    initial begin
        rst_n    = 1'b0;
        link_sel = 1'b0;
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        t_reset();
        t_modes();
        t_error();
        t_abort();
        close_out();
    end
endmodule

bind jrxcfg_top jrxcfg_top_assertions #(.NUM_LANES(NUM_LANES)) i_jrxcfg_top_assertions (.clock(clock),
    .rst_n(rst_n), .spi_cs_n(spi_cs_n), .link_sel(link_sel), .link_cfg(link_cfg), .deskew_lanes(deskew_lanes),
    .enabled_lanes(enabled_lanes), .link_deskew(link_deskew), .link_enable(link_enable),
    .true_lane_count(true_lane_count), .cfg_error(cfg_error));
`default_nettype wire
